// ### hdl/liucc_defines.vh
`ifndef LIUCC_DEFINES_VH
`define LIUCC_DEFINES_VH

// register word indexes, byte address is index * 4
`define LIUCC_IDX_CCR3         2'h0
`define LIUCC_IDX_CFG          2'h1
`define LIUCC_IDX_STATUS       2'h2
`define LIUCC_ADDR_LSB         2

// liu_channel_control_three fields
`define LIUCC_CCR3_CODING      5
`define LIUCC_CCR3_RSVD_HI     4
`define LIUCC_CCR3_RSVD_LO     3
`define LIUCC_CCR3_BPV         2
`define LIUCC_CCR3_BER         1
`define LIUCC_CCR3_MUTE        0
`define LIUCC_CCR3_RESET       8'h00
`define LIUCC_CCR3_WMASK       8'h3F

// configuration register fields
`define LIUCC_CFG_SINGLE       0
`define LIUCC_CFG_PAT_LO       1
`define LIUCC_CFG_PAT_HI       3
`define LIUCC_CFG_RESET        8'h01
`define LIUCC_CFG_WMASK        8'h0F

// status register fields
`define LIUCC_ST_LOS           0
`define LIUCC_ST_BPV_PEND      1
`define LIUCC_ST_BER_PEND      2
`define LIUCC_ST_BPV_CNT_LO    8
`define LIUCC_ST_BER_CNT_LO    16

// transmit test pattern codes
`define LIUCC_PAT_DATA         3'h0
`define LIUCC_PAT_QRSS         3'h4

// coding select values
`define LIUCC_CODE_B8ZS        1'h0
`define LIUCC_CODE_AMI         1'h1

// substitution word 000VB0VB, oldest bit at index 7
`define LIUCC_SUB_MARKS        8'h1B
`define LIUCC_SUB_VIOLS        8'h12

// qrss generator: 20 stage lfsr, taps 20 and 17, zero limit 14
`define LIUCC_QRSS_LEN         20
`define LIUCC_QRSS_TAP         16
`define LIUCC_QRSS_SEED        20'hFFFFF
`define LIUCC_QRSS_ZMAX        4'hE

`define LIUCC_RESP_OKAY        2'h0
`define LIUCC_RESP_DECERR      2'h3

`endif

// ### hdl/liucc_edge.v
`timescale 1ns/1ps
`default_nettype none
module liucc_edge (
  input  wire aclk,
  input  wire aresetn,
  input  wire level,
  output wire rise
);
  reg prev;

  always @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
endmodule
`default_nettype wire

// ### hdl/liucc_sync.v
`timescale 1ns/1ps
`default_nettype none
module liucc_sync #(
  parameter WIDTH = 1
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta;

  // meta feeds q only
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= {WIDTH{1'b0}};
      q    <= {WIDTH{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// ### hdl/liucc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "liucc_defines.vh"
module liucc_top #(
  parameter AW = 4
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire [2:0]    s_axi_awprot,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire [2:0]    s_axi_arprot,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire          tx_channel_clock,
  input  wire          tx_data_in,
  input  wire          tx_neg_in,
  output reg           tx_pos_out,
  output reg           tx_neg_out,
  input  wire          rx_recovered_clock,
  input  wire          rx_master_clock,
  input  wire          rx_loss_of_signal,
  input  wire          rx_pos_in,
  input  wire          rx_neg_in,
  output reg           rx_data_out,
  output reg           rx_neg_out,
  output reg           rx_serial_clock_out
);

  // ---------------- pin synchronisers ----------------
  wire [7:0] pins_s;
  wire       txclk_s  = pins_s[0];
  wire       txd_s    = pins_s[1];
  wire       txn_s    = pins_s[2];
  wire       rclk_s   = pins_s[3];
  wire       mclk_s   = pins_s[4];
  wire       los_s    = pins_s[5];
  wire       rxp_s    = pins_s[6];
  wire       rxn_s    = pins_s[7];
  wire       tx_tick;
  wire       rx_tick;

  liucc_sync #(.WIDTH(8)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({rx_neg_in, rx_pos_in, rx_loss_of_signal, rx_master_clock,
                rx_recovered_clock, tx_neg_in, tx_data_in, tx_channel_clock}),
    .q       (pins_s)
  );

  liucc_edge u_tx_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (txclk_s),
    .rise    (tx_tick)
  );

  liucc_edge u_rx_edge (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (rclk_s),
    .rise    (rx_tick)
  );

  // ---------------- register file over AXI4-Lite ----------------
  reg  [7:0]    liu_channel_control_three;
  reg  [7:0]    cfg;
  reg           aw_held;
  reg           w_held;
  reg  [AW-1:0] aw_addr;
  reg  [31:0]   w_data;
  reg  [3:0]    w_strb;
  reg           bpv_pend;
  reg           ber_pend;
  reg  [7:0]    bpv_cnt;
  reg  [7:0]    ber_cnt;

  wire          line_coding_select      = liu_channel_control_three[`LIUCC_CCR3_CODING];
  wire          insert_bipolar_violation = liu_channel_control_three[`LIUCC_CCR3_BPV];
  wire          insert_single_bit_error = liu_channel_control_three[`LIUCC_CCR3_BER];
  wire          rx_clock_mute_on_los    = liu_channel_control_three[`LIUCC_CCR3_MUTE];
  wire          single_rail             = cfg[`LIUCC_CFG_SINGLE];
  wire [2:0]    tx_test_pattern_select  = cfg[`LIUCC_CFG_PAT_HI:`LIUCC_CFG_PAT_LO];
  wire          b8zs_on  = single_rail & (line_coding_select == `LIUCC_CODE_B8ZS);
  wire          qrss_on  = single_rail & (tx_test_pattern_select == `LIUCC_PAT_QRSS);

  function [1:0] reg_index;
    input [AW-1:0] addr;
    begin
      reg_index = addr[`LIUCC_ADDR_LSB+1:`LIUCC_ADDR_LSB];
    end
  endfunction

  function mapped;
    input [AW-1:0] addr;
    begin
      mapped = ((addr >> (`LIUCC_ADDR_LSB + 2)) == {AW{1'b0}}) &&
               (reg_index(addr) <= `LIUCC_IDX_STATUS);
    end
  endfunction

  wire do_write = aw_held & w_held & ~s_axi_bvalid;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held                   <= 1'b0;
      w_held                    <= 1'b0;
      aw_addr                   <= {AW{1'b0}};
      w_data                    <= 32'h00000000;
      w_strb                    <= 4'h0;
      s_axi_bvalid              <= 1'b0;
      s_axi_bresp               <= `LIUCC_RESP_OKAY;
      liu_channel_control_three <= `LIUCC_CCR3_RESET;
      cfg                       <= `LIUCC_CFG_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? `LIUCC_RESP_OKAY : `LIUCC_RESP_DECERR;
        if (mapped(aw_addr) && w_strb[0]) begin
          case (reg_index(aw_addr))
            `LIUCC_IDX_CCR3: begin
              liu_channel_control_three <= w_data[7:0] & `LIUCC_CCR3_WMASK;
            end
            `LIUCC_IDX_CFG: begin
              cfg <= w_data[7:0] & `LIUCC_CFG_WMASK;
            end
            default: begin
            end
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `LIUCC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? `LIUCC_RESP_OKAY : `LIUCC_RESP_DECERR;
      s_axi_rdata  <= 32'h00000000;
      if (mapped(s_axi_araddr)) begin
        case (reg_index(s_axi_araddr))
          `LIUCC_IDX_CCR3: begin
            s_axi_rdata <= {24'h000000, liu_channel_control_three};
          end
          `LIUCC_IDX_CFG: begin
            s_axi_rdata <= {24'h000000, cfg};
          end
          `LIUCC_IDX_STATUS: begin
            s_axi_rdata <= {8'h00, ber_cnt, bpv_cnt, 5'h00, ber_pend, bpv_pend, los_s};
          end
          default: begin
            s_axi_rdata <= 32'h00000000;
          end
        endcase
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- insert request capture at transmit clock edges ----------------
  // two stages clocked by tx edges, third stage only for edge detection
  reg  [2:0] bpv_smp;
  reg  [2:0] ber_smp;
  wire       bpv_rise = bpv_smp[1] & ~bpv_smp[2];
  wire       ber_rise = ber_smp[1] & ~ber_smp[2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      bpv_smp <= 3'h0;
      ber_smp <= 3'h0;
    end else if (tx_tick) begin
      bpv_smp <= {bpv_smp[1:0], insert_bipolar_violation};
      ber_smp <= {ber_smp[1:0], insert_single_bit_error};
    end
  end

  // ---------------- qrss generator ----------------
  reg  [`LIUCC_QRSS_LEN-1:0] lfsr;
  reg  [3:0]                 zrun;
  wire                       lfsr_fb  = lfsr[`LIUCC_QRSS_LEN-1] ^ lfsr[`LIUCC_QRSS_TAP];
  // zero suppression keeps at most 14 consecutive zeros on the line
  wire                       qrss_bit = (zrun == `LIUCC_QRSS_ZMAX) ? 1'b1 : lfsr_fb;

  always @(posedge aclk) begin
    if (!aresetn) begin
      lfsr <= `LIUCC_QRSS_SEED;
      zrun <= 4'h0;
    end else if (tx_tick && qrss_on) begin
      lfsr <= {lfsr[`LIUCC_QRSS_LEN-2:0], lfsr_fb};
      zrun <= qrss_bit ? 4'h0 : zrun + 4'h1;
    end
  end

  // ---------------- transmit encoder ----------------
  // fixed 8-bit delay in both codings so switching AMI/B8ZS keeps latency
  reg  [7:0] tx_d;
  reg  [7:0] tx_v;
  reg        tx_last_pos;
  wire       src_bit  = qrss_on ? (qrss_bit ^ ber_pend) : txd_s;
  wire [7:0] next_d   = {tx_d[6:0], src_bit};
  wire       out_mark = tx_d[7];
  wire       out_viol = tx_v[7] | bpv_pend;
  wire       next_pos = out_viol ? tx_last_pos : ~tx_last_pos;

  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_d        <= 8'h00;
      tx_v        <= 8'h00;
      tx_last_pos <= 1'b0;
      tx_pos_out  <= 1'b0;
      tx_neg_out  <= 1'b0;
      bpv_pend    <= 1'b0;
      ber_pend    <= 1'b0;
      bpv_cnt     <= 8'h00;
      ber_cnt     <= 8'h00;
    end else if (tx_tick) begin
      if (!single_rail) begin
        tx_pos_out <= txd_s;
        tx_neg_out <= txn_s;
        bpv_pend   <= 1'b0;
        ber_pend   <= 1'b0;
      end else begin
        if (b8zs_on && next_d == 8'h00) begin
          tx_d <= `LIUCC_SUB_MARKS;
          tx_v <= `LIUCC_SUB_VIOLS;
        end else begin
          tx_d <= next_d;
          tx_v <= {tx_v[6:0], 1'b0};
        end
        tx_pos_out <= out_mark & next_pos;
        tx_neg_out <= out_mark & ~next_pos;
        if (out_mark) begin
          tx_last_pos <= next_pos;
        end
        // one violation per rise, spent on the next mark that is not already a V
        if (bpv_rise) begin
          bpv_pend <= 1'b1;
        end else if (out_mark && !tx_v[7] && bpv_pend) begin
          bpv_pend <= 1'b0;
          bpv_cnt  <= bpv_cnt + 8'h01;
        end
        // error applied to the bit leaving the generator on the tick after the rise
        if (ber_rise && qrss_on) begin
          ber_pend <= 1'b1;
        end else if (ber_pend) begin
          ber_pend <= 1'b0;
          ber_cnt  <= ber_cnt + 8'h01;
        end
      end
    end
  end

  // ---------------- receive decoder ----------------
  reg  [7:0] rx_d;
  reg  [7:0] rx_v;
  reg        rx_last_pos;
  wire       rx_mark  = rxp_s | rxn_s;
  wire       rx_viol  = rx_mark & (rxp_s == rx_last_pos);
  wire [7:0] rx_nd    = {rx_d[6:0], rx_mark};
  wire [7:0] rx_nv    = {rx_v[6:0], rx_viol};
  wire       rx_sub   = b8zs_on && (rx_nd == `LIUCC_SUB_MARKS) && (rx_nv == `LIUCC_SUB_VIOLS);

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_d        <= 8'h00;
      rx_v        <= 8'h00;
      rx_last_pos <= 1'b0;
      rx_data_out <= 1'b0;
      rx_neg_out  <= 1'b0;
    end else if (rx_tick) begin
      if (!single_rail) begin
        rx_data_out <= rxp_s;
        rx_neg_out  <= rxn_s;
      end else begin
        rx_data_out <= rx_d[7];
        rx_neg_out  <= 1'b0;
        if (rx_mark) begin
          rx_last_pos <= rxp_s;
        end
        rx_d <= rx_sub ? 8'h00 : rx_nd;
        rx_v <= rx_sub ? 8'h00 : rx_nv;
      end
    end
  end

  // ---------------- receive serial clock selection ----------------
  // clocks are re-sampled by aclk, so the output carries up to 20 ns of jitter
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_serial_clock_out <= 1'b0;
    end else if (!los_s) begin
      rx_serial_clock_out <= rclk_s;
    end else if (rx_clock_mute_on_los) begin
      rx_serial_clock_out <= 1'b0;
    end else begin
      rx_serial_clock_out <= mclk_s;
    end
  end

endmodule
`default_nettype wire

// ### test/liu_channel_coding_error_inject_tb.sv
`timescale 1ns/1ps
`default_nettype none
module liu_channel_coding_error_inject_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, los, ones;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [1:0]  rr;
  wire         awready, wready, bvalid, arready, rvalid, tx_clk, mclk, tx_d, tx_n, tx_p_o, tx_n_o, rx_clk_o;
  wire         rx_d_o, rx_n_o;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          n_errors, cmp_count, dm, dv, dr, dn;
  liucc_top #(.AW(4)) u_liucc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tx_channel_clock(tx_clk), .tx_data_in(tx_d), .tx_neg_in(tx_n), .tx_pos_out(tx_p_o),
    .tx_neg_out(tx_n_o), .rx_recovered_clock(tx_clk), .rx_master_clock(mclk), .rx_loss_of_signal(los),
    .rx_pos_in(tx_p_o), .rx_neg_in(tx_n_o), .rx_data_out(rx_d_o), .rx_neg_out(rx_n_o),
    .rx_serial_clock_out(rx_clk_o));
  liucc_line_model u_liucc_line_model (
    .ones(ones), .tx_pos_out(tx_p_o), .tx_neg_out(tx_n_o), .tx_channel_clock(tx_clk), .rx_master_clock(mclk),
    .tx_data_in(tx_d), .tx_neg_in(tx_n));
  always #10 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rr = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge tx_clk);
  endtask
  // marks, violations and received highs over 16 ticks once both 8-tick pipes are full
  task automatic line_cnt;
    int m, v;
    ticks(24);
    m = u_liucc_line_model.marks;
    v = u_liucc_line_model.viols;
    dr = 0;
    dn = 0;
    repeat (16) begin
      @(negedge tx_clk);
      dr += rx_d_o;
      dn += rx_n_o;
    end
    dm = u_liucc_line_model.marks - m;
    dv = u_liucc_line_model.viols - v;
  endtask
  task automatic toggles(output int n);
    logic p;
    n = 0;
    repeat (8) @(posedge aclk);
    p = rx_clk_o;
    repeat (60) begin
      @(posedge aclk);
      if (rx_clk_o !== p) n++;
      p = rx_clk_o;
    end
  endtask
  task automatic t_regs;
    rd_reg(4'h0);
    chk(rd, 32'h0);
    rd_reg(4'h4);
    chk(rd, 32'h1);
    wr(4'h0, 32'hFFFF_FF38);
    rd_reg(4'h0);
    chk(rd, 32'h38);
    wr(4'hC, 32'h1);
    chk(rr, 2'h3);
    rd_reg(4'hC);
    chk({rd[31:2], rr}, 32'h3);
    $display("test regs done");
  endtask
  task automatic t_coding;
    wr(4'h0, 32'h00);
    line_cnt;
    chk({dm[15:0], dv[15:0]}, 32'h0008_0004);
    chk({dr[15:0], dn[15:0]}, 32'h0000_0000);
    wr(4'h0, 32'h20);
    line_cnt;
    chk(dm, 0);
    @(posedge aclk);
    ones <= 1'b1;
    line_cnt;
    chk({dm[15:0], dv[15:0]}, 32'h0010_0000);
    chk({dr[15:0], dn[15:0]}, 32'h0010_0000);
    $display("test coding done");
  endtask
  // dual-rail: rails copied straight through, coding bypassed both ways
  task automatic t_dual;
    wr(4'h4, 32'h00);
    line_cnt;
    chk({dm[15:0], dv[15:0]}, 32'h0010_0010);
    chk({dr[15:0], dn[15:0]}, 32'h0010_0008);
    wr(4'h4, 32'h01);
    $display("test dual rail done");
  endtask
  task automatic t_bpv;
    int v;
    v = u_liucc_line_model.viols;
    wr(4'h0, 32'h24);
    ticks(20);
    chk(u_liucc_line_model.viols - v, 1);
    wr(4'h0, 32'h24);
    ticks(20);
    chk(u_liucc_line_model.viols - v, 1);
    rd_reg(4'h8);
    chk(rd[15:8], 8'h01);
    $display("test violation done");
  endtask
  task automatic t_ber;
    wr(4'h0, 32'h20);
    wr(4'h0, 32'h22);
    ticks(20);
    rd_reg(4'h8);
    chk(rd[23:16], 8'h00);
    wr(4'h4, 32'h09);
    wr(4'h0, 32'h20);
    // the 0 must be seen by at least one transmit tick before the 1 lands
    ticks(2);
    wr(4'h0, 32'h22);
    ticks(20);
    rd_reg(4'h8);
    chk(rd[23:16], 8'h01);
    wr(4'h4, 32'h01);
    $display("test bit error done");
  endtask
  task automatic t_rxclk;
    int n;
    @(posedge aclk);
    los <= 1'b1;
    wr(4'h0, 32'h20);
    toggles(n);
    chk(n, 20);
    rd_reg(4'h8);
    chk(rd[0], 1'b1);
    wr(4'h0, 32'h21);
    toggles(n);
    chk({n[30:0], rx_clk_o}, 32'h0);
    @(posedge aclk);
    los <= 1'b0;
    toggles(n);
    chk(n, 15);
    $display("test receive clock done");
  endtask
  task automatic final_report;
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    final_report;
  end
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, los, ones} = '0;
    {awaddr, araddr, wdata, n_errors, cmp_count} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_coding;
    t_bpv;
    t_ber;
    t_dual;
    t_rxclk;
    final_report;
  end
endmodule
`default_nettype wire

// ### test/liucc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module liucc_line_model (
  input  wire logic ones,
  input  wire logic tx_pos_out,
  input  wire logic tx_neg_out,
  output var logic  tx_channel_clock,
  output var logic  rx_master_clock,
  output var logic  tx_data_in,
  output var logic  tx_neg_in
);
  int   marks;
  int   viols;
  logic last_pol;
  initial begin
    tx_channel_clock = 1'b0;
    rx_master_clock = 1'b0;
    tx_data_in = 1'b0;
    tx_neg_in = 1'b0;
    marks = 0;
    viols = 0;
    last_pol = 1'b0;
  end
  // edges kept off the aclk rising edges so sampling never races
  always #80 tx_channel_clock = ~tx_channel_clock;
  always #60 rx_master_clock = ~rx_master_clock;
  // line read mid-bit, clear of the tick latency
  always @(negedge tx_channel_clock) begin
    tx_data_in <= ones;
    tx_neg_in <= ~tx_neg_in;
    if (tx_pos_out || tx_neg_out) begin
      if (marks != 0 && tx_pos_out == last_pol)
        viols <= viols + 1;
      marks <= marks + 1;
      last_pol <= tx_pos_out;
    end
  end
endmodule
`default_nettype wire

// ### test/liucc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module liucc_top_asserts #(
  parameter AW = 4
) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic [1:0]    s_axi_rresp,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic          tx_channel_clock,
  input wire logic          tx_pos_out,
  input wire logic          tx_neg_out,
  input wire logic          rx_recovered_clock,
  input wire logic          rx_master_clock,
  input wire logic          rx_loss_of_signal,
  input wire logic          rx_serial_clock_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken during response");
  property p_w_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_w_take: assert property (p_w_take) else $error("write response late");
  property p_ar_take; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_ar_take: assert property (p_ar_take) else $error("read response late");
  property p_r_unmap; s_axi_arvalid && s_axi_arready && s_axi_araddr >= 'hC |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0; endproperty
  a_r_unmap: assert property (p_r_unmap) else $error("unmapped read not refused");
  property p_rxclk_norm; !rx_loss_of_signal [*6] |-> rx_serial_clock_out == $past(rx_recovered_clock, 3); endproperty
  a_rxclk_norm: assert property (p_rxclk_norm) else $error("recovered clock not passed");
  property p_rxclk_los; rx_loss_of_signal [*6] |-> !rx_serial_clock_out || rx_serial_clock_out == $past(rx_master_clock, 3); endproperty
  a_rxclk_los: assert property (p_rxclk_los) else $error("wrong clock during signal loss");
  property p_tx_tick;
    $changed(tx_pos_out) || $changed(tx_neg_out) |->
      $past(tx_channel_clock, 2) || $past(tx_channel_clock, 3) || $past(tx_channel_clock, 4) || $past(tx_channel_clock, 5);
  endproperty
  a_tx_tick: assert property (p_tx_tick) else $error("line changed off a transmit tick");
endmodule
bind liucc_top liucc_top_asserts #(.AW(AW)) u_liucc_top_asserts (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .tx_channel_clock(tx_channel_clock), .tx_pos_out(tx_pos_out),
  .tx_neg_out(tx_neg_out), .rx_recovered_clock(rx_recovered_clock), .rx_master_clock(rx_master_clock),
  .rx_loss_of_signal(rx_loss_of_signal), .rx_serial_clock_out(rx_serial_clock_out));
`default_nettype wire
